// File: rtl/pwu_pkg.sv
// shared constants for the port wakeup interrupt unit
package pwu_pkg;

   // register indices as printed; the byte address is four times the index
   localparam logic [7:0] PWU_IDX_ENABLE_MAIN     = 8'hA8;
   localparam logic [7:0] PWU_IDX_PRIORITY_MAIN   = 8'hB8;
   localparam logic [7:0] PWU_IDX_EXTRA_REQUEST   = 8'hC0;
   localparam logic [7:0] PWU_IDX_EXTRA_ENABLE    = 8'hE8;
   localparam logic [7:0] PWU_IDX_EXTRA_POLARITY  = 8'hE9;
   localparam logic [7:0] PWU_IDX_EXTRA_PRIORITY  = 8'hF8;
   localparam logic [7:0] PWU_IDX_SERVICE_STATUS  = 8'hF0;

   // apb byte addresses
   localparam int         PWU_AW = 10;
   localparam logic [9:0] PWU_ADDR_ENABLE_MAIN    = {PWU_IDX_ENABLE_MAIN, 2'b00};
   localparam logic [9:0] PWU_ADDR_PRIORITY_MAIN  = {PWU_IDX_PRIORITY_MAIN, 2'b00};
   localparam logic [9:0] PWU_ADDR_EXTRA_REQUEST  = {PWU_IDX_EXTRA_REQUEST, 2'b00};
   localparam logic [9:0] PWU_ADDR_EXTRA_ENABLE   = {PWU_IDX_EXTRA_ENABLE, 2'b00};
   localparam logic [9:0] PWU_ADDR_EXTRA_POLARITY = {PWU_IDX_EXTRA_POLARITY, 2'b00};
   localparam logic [9:0] PWU_ADDR_EXTRA_PRIORITY = {PWU_IDX_EXTRA_PRIORITY, 2'b00};
   localparam logic [9:0] PWU_ADDR_SERVICE_STATUS = {PWU_IDX_SERVICE_STATUS, 2'b00};

   // bit positions in enable_main and priority_main
   localparam int PWU_BIT_EXT0   = 0;
   localparam int PWU_BIT_TMR0   = 1;
   localparam int PWU_BIT_EXT1   = 2;
   localparam int PWU_BIT_TMR1   = 3;
   localparam int PWU_BIT_SER    = 5;
   localparam int PWU_BIT_GLOBAL = 7;

   // bit positions in service_status
   localparam int PWU_ST_INS_LO  = 0;
   localparam int PWU_ST_INS_HI  = 1;
   localparam int PWU_ST_PENDING = 2;
   localparam int PWU_ST_LEVEL   = 3;

   // sources and extra inputs
   localparam int PWU_NSRC   = 13;
   localparam int PWU_NEXTRA = 8;

   // polling position of each source, position 0 is polled first
   localparam logic [3:0] PWU_POS_EXT0 = 4'h0;
   localparam logic [3:0] PWU_POS_SER  = 4'h1;
   localparam logic [3:0] PWU_POS_TMR0 = 4'h3;
   localparam logic [3:0] PWU_POS_EXT1 = 4'h5;
   localparam logic [3:0] PWU_POS_TMR1 = 4'h8;
   // polling position of extra input k (k = 0 is external 2, k = 7 is external 9)
   localparam logic [3:0] PWU_POS_EXTRA [PWU_NEXTRA] = '{
      4'h6, 4'h9, 4'hB, 4'h2, 4'h4, 4'h7, 4'hA, 4'hC};

   // vector address for each polling position
   localparam logic [15:0] PWU_VECTOR [PWU_NSRC] = '{
      16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h005B, 16'h0013, 16'h003B,
      16'h0063, 16'h001B, 16'h0043, 16'h006B, 16'h004B, 16'h0073};

   // reset values
   localparam logic [7:0]  PWU_RST_BYTE   = 8'h00;
   localparam logic [15:0] PWU_RST_VECTOR = 16'h0000;

   // priority levels
   typedef enum logic {
      PWU_LVL_LOW  = 1'b0,
      PWU_LVL_HIGH = 1'b1
   } pwu_level_e;

endpackage : pwu_pkg

// File: rtl/pwu_pick.sv
// fixed-order picker: lowest pending polling position wins
`timescale 1ns/1ps
module pwu_pick
   import pwu_pkg::*;
(
   // pending requests by polling position
   input  wire logic [PWU_NSRC-1:0] pending,
   // winner
   output logic                     found,
   output logic [3:0]               position
);

   // scan from the last position down so the last one found, the lowest, sticks
   always_comb begin
      found    = 1'b0;
      position = 4'h0;
      for (int i = PWU_NSRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            found    = 1'b1;
            position = 4'(i);
         end
      end
   end

endmodule // pwu_pick

// File: rtl/pwu_top.sv
// port wakeup interrupt unit: thirteen-source, two-level vectored controller
//
// Notes on behaviour
// - one enable bit per extra input
// - one priority bit per extra input
// - polarity bit one means active high
// - readable sticky request flag per extra input
// - bit 0 is external 2, bit 7 external 9
// - fixed polling order within one level
// - fixed vector address for each source
// - flag set by hardware, cleared only by software
// - enabled extra inputs wake from power-down
// - global enable masks all sources at once
// - thirteen sources, two nested priority levels
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pwu_top
   import pwu_pkg::*;
(
   // clock and reset
   input  wire logic              CLK_SYS,
   input  wire logic              NRST,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [PWU_AW-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // classic sources, active-high levels
   input  wire logic              EXT_INPUT_ZERO,
   input  wire logic              EXT_INPUT_ONE,
   input  wire logic              TIMER_ZERO_SOURCE,
   input  wire logic              TIMER_ONE_SOURCE,
   input  wire logic              TWO_WIRE_PORT_SOURCE,
   // extra external inputs, bit 0 is external 2
   input  wire logic [7:0]        EXT_INPUT_EXTRA,
   // cpu core side
   input  wire logic              IRQ_ACK,
   input  wire logic              IRQ_RETI,
   output logic                   IRQ_REQ,
   output logic [15:0]            IRQ_VECTOR,
   // power-down wake
   input  wire logic              POWER_DOWN,
   output logic                   WAKE_UP
);

   // software registers
   logic [7:0]  enable_main_q,    enable_main_d;     // classic enables and global
   logic [7:0]  priority_main_q,  priority_main_d;   // classic priority bits
   logic [7:0]  extra_request_q,  extra_request_d;   // sticky extra flags
   logic [7:0]  extra_enable_q,   extra_enable_d;    // extra enables
   logic [7:0]  extra_polarity_q, extra_polarity_d;  // extra active levels
   logic [7:0]  extra_priority_q, extra_priority_d;  // extra priority bits
   // bus answer registers
   logic [31:0] rdata_q,          rdata_d;           // read data for access phase
   logic        slverr_q,         slverr_d;          // unmapped address seen in setup
   // service state
   logic        ins_lo_q,         ins_lo_d;          // low-level routine running
   logic        ins_hi_q,         ins_hi_d;          // high-level routine running
   logic        irq_req_q,        irq_req_d;         // request offered to the core
   logic [15:0] vector_q,         vector_d;          // vector offered to the core
   pwu_level_e  level_q,          level_d;           // level of the offered request
   logic        wake_q,           wake_d;            // registered wake level
   // combinational helpers
   logic        bus_setup;                           // setup phase of any transfer
   logic        bus_write;                           // write taking effect now
   logic        addr_hit;                            // address is mapped
   logic [7:0]  wbyte;                               // written byte
   logic [7:0]  extra_active;                        // extra pins at active level
   logic [7:0]  extra_set;                           // flags to set this cycle
   logic [PWU_NSRC-1:0] pending;                     // enabled requests by position
   logic [PWU_NSRC-1:0] high_level;                  // priority bit by position
   logic        hi_found,         lo_found;          // picker outputs
   logic [3:0]  hi_pos,           lo_pos;
   logic [7:0]  status_byte;                         // service status readback

   // apb phase decode; a write lands only in the access phase,
   // while read data is captured in the setup phase
   assign bus_setup = PSEL & ~PENABLE;
   assign bus_write = PSEL & PENABLE & PWRITE;
   assign wbyte     = PWDATA[7:0];

   // single-cycle access phase, answer always ready
   // every register is a plain flip-flop, so no wait state is ever needed
   assign PREADY  = 1'b1;
   assign PRDATA  = rdata_q;
   assign PSLVERR = slverr_q & PSEL & PENABLE;

   // address decode, the low two bits must be zero for a hit
   // misaligned and unmapped words both miss and answer with an error
   always_comb begin
      unique case (PADDR)
         PWU_ADDR_ENABLE_MAIN,
         PWU_ADDR_PRIORITY_MAIN,
         PWU_ADDR_EXTRA_REQUEST,
         PWU_ADDR_EXTRA_ENABLE,
         PWU_ADDR_EXTRA_POLARITY,
         PWU_ADDR_EXTRA_PRIORITY,
         PWU_ADDR_SERVICE_STATUS: addr_hit = 1'b1;
         default:                 addr_hit = 1'b0;
      endcase
   end

   // level-sensitive: a pin held active keeps setting its flag, so software
   // must remove the cause first or its clear is lost
   // polarity compare, one means a high pin is active
   assign extra_active = ~(EXT_INPUT_EXTRA ^ extra_polarity_q);
   // enable gates the flag set; bit k is external k+2
   assign extra_set = extra_active & extra_enable_q;

   // status byte seen by software
   // read-only word; writes to it are dropped without an error
   always_comb begin
      status_byte                 = PWU_RST_BYTE;
      status_byte[PWU_ST_INS_LO]  = ins_lo_q;
      status_byte[PWU_ST_INS_HI]  = ins_hi_q;
      status_byte[PWU_ST_PENDING] = irq_req_q;
      status_byte[PWU_ST_LEVEL]   = level_q;
   end

   // register writes and read data capture
   // bytes are stored whole, so unused classic bits read back as written
   always_comb begin
      enable_main_d    = enable_main_q;
      priority_main_d  = priority_main_q;
      extra_enable_d   = extra_enable_q;
      extra_polarity_d = extra_polarity_q;
      extra_priority_d = extra_priority_q;
      extra_request_d  = extra_request_q;
      rdata_d          = rdata_q;
      slverr_d         = slverr_q;
      if (bus_write) begin
         unique case (PADDR)
            PWU_ADDR_ENABLE_MAIN:    enable_main_d    = wbyte;
            PWU_ADDR_PRIORITY_MAIN:  priority_main_d  = wbyte;
            PWU_ADDR_EXTRA_REQUEST:  extra_request_d  = wbyte;
            PWU_ADDR_EXTRA_ENABLE:   extra_enable_d   = wbyte;
            PWU_ADDR_EXTRA_POLARITY: extra_polarity_d = wbyte;
            PWU_ADDR_EXTRA_PRIORITY: extra_priority_d = wbyte;
            // status and unmapped words ignore writes
            default: ;
         endcase
      end
      // hardware sets flags, set wins over a software clear
      extra_request_d = extra_request_d | extra_set;
      // read data is latched in setup so it comes from a flip-flop
      if (bus_setup) begin
         slverr_d = ~addr_hit;
         rdata_d  = 32'h0000_0000;
         unique case (PADDR)
            PWU_ADDR_ENABLE_MAIN:    rdata_d[7:0] = enable_main_q;
            PWU_ADDR_PRIORITY_MAIN:  rdata_d[7:0] = priority_main_q;
            PWU_ADDR_EXTRA_REQUEST:  rdata_d[7:0] = extra_request_q;
            PWU_ADDR_EXTRA_ENABLE:   rdata_d[7:0] = extra_enable_q;
            PWU_ADDR_EXTRA_POLARITY: rdata_d[7:0] = extra_polarity_q;
            PWU_ADDR_EXTRA_PRIORITY: rdata_d[7:0] = extra_priority_q;
            PWU_ADDR_SERVICE_STATUS: rdata_d      = {vector_q, 8'h00, status_byte};
            default: ;
         endcase
      end
   end

   // register file flip-flops
   // every register clears to zero, so all sources start masked
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         enable_main_q    <= PWU_RST_BYTE;
         priority_main_q  <= PWU_RST_BYTE;
         extra_request_q  <= PWU_RST_BYTE;
         extra_enable_q   <= PWU_RST_BYTE;
         extra_polarity_q <= PWU_RST_BYTE;
         extra_priority_q <= PWU_RST_BYTE;
         rdata_q          <= 32'h0000_0000;
         slverr_q         <= 1'b0;
      end else begin
         enable_main_q    <= enable_main_d;
         priority_main_q  <= priority_main_d;
         extra_request_q  <= extra_request_d;
         extra_enable_q   <= extra_enable_d;
         extra_polarity_q <= extra_polarity_d;
         extra_priority_q <= extra_priority_d;
         rdata_q          <= rdata_d;
         slverr_q         <= slverr_d;
      end
   end

   // map all thirteen sources onto their polling positions
   always_comb begin
      pending    = '0;
      high_level = '0;
      // classic sources are plain levels and must hold until serviced
      // five classic sources
      pending[PWU_POS_EXT0] = EXT_INPUT_ZERO       & enable_main_q[PWU_BIT_EXT0];
      pending[PWU_POS_SER]  = TWO_WIRE_PORT_SOURCE & enable_main_q[PWU_BIT_SER];
      pending[PWU_POS_TMR0] = TIMER_ZERO_SOURCE    & enable_main_q[PWU_BIT_TMR0];
      pending[PWU_POS_EXT1] = EXT_INPUT_ONE        & enable_main_q[PWU_BIT_EXT1];
      pending[PWU_POS_TMR1] = TIMER_ONE_SOURCE     & enable_main_q[PWU_BIT_TMR1];
      high_level[PWU_POS_EXT0] = priority_main_q[PWU_BIT_EXT0];
      high_level[PWU_POS_SER]  = priority_main_q[PWU_BIT_SER];
      high_level[PWU_POS_TMR0] = priority_main_q[PWU_BIT_TMR0];
      high_level[PWU_POS_EXT1] = priority_main_q[PWU_BIT_EXT1];
      high_level[PWU_POS_TMR1] = priority_main_q[PWU_BIT_TMR1];
      // eight extra sources; enable masks the serviced flag
      for (int k = 0; k < PWU_NEXTRA; k++) begin
         pending[PWU_POS_EXTRA[k]]    = extra_request_q[k] & extra_enable_q[k];
         high_level[PWU_POS_EXTRA[k]] = extra_priority_q[k];
      end
      // global enable masks everything at once
      if (!enable_main_q[PWU_BIT_GLOBAL]) begin
         pending = '0;
      end
   end

   // fixed polling order, one picker per level
   // both levels are picked every cycle; the nesting logic chooses
   pwu_pick u_pick_hi (
      .pending  (pending & high_level),
      .found    (hi_found),
      .position (hi_pos)
   );

   pwu_pick u_pick_lo (
      .pending  (pending & ~high_level),
      .found    (lo_found),
      .position (lo_pos)
   );

   // nesting state and the request offered to the core
   always_comb begin
      ins_lo_d  = ins_lo_q;
      ins_hi_d  = ins_hi_q;
      irq_req_d = 1'b0;
      vector_d  = vector_q;
      level_d   = level_q;
      // return leaves the most recent, i.e. highest, active level
      if (IRQ_RETI) begin
         if (ins_hi_q) begin
            ins_hi_d = 1'b0;
         end else begin
            ins_lo_d = 1'b0;
         end
      end
      // the offer is rebuilt every cycle, so a new high request replaces a
      // waiting low one before the core takes it; an acknowledge with no
      // offer standing is ignored
      // the offered vector is taken; the request drops for one cycle
      if (IRQ_ACK && irq_req_q) begin
         if (level_q == PWU_LVL_HIGH) begin
            ins_hi_d = 1'b1;
         end else begin
            ins_lo_d = 1'b1;
         end
      end else begin
         // high may preempt low only; nothing preempts high
         if (hi_found && !ins_hi_q) begin
            irq_req_d = 1'b1;
            level_d   = PWU_LVL_HIGH;
            vector_d  = PWU_VECTOR[hi_pos];
         // low is offered only when no routine runs
         end else if (lo_found && !ins_hi_q && !ins_lo_q) begin
            irq_req_d = 1'b1;
            level_d   = PWU_LVL_LOW;
            vector_d  = PWU_VECTOR[lo_pos];
         end
      end
   end

   // wake comes from a flip-flop, like every other data output
   always_comb begin
      // any enabled extra input at its active level wakes the core
      wake_d = POWER_DOWN & (|extra_set);
   end

   // service flip-flops
   // reset leaves no routine in service and nothing offered
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         ins_lo_q  <= 1'b0;
         ins_hi_q  <= 1'b0;
         irq_req_q <= 1'b0;
         vector_q  <= PWU_RST_VECTOR;
         level_q   <= PWU_LVL_LOW;
         wake_q    <= 1'b0;
      end else begin
         ins_lo_q  <= ins_lo_d;
         ins_hi_q  <= ins_hi_d;
         irq_req_q <= irq_req_d;
         vector_q  <= vector_d;
         level_q   <= level_d;
         wake_q    <= wake_d;
      end
   end

   // core side and wake outputs come straight from flip-flops
   assign IRQ_REQ    = irq_req_q;
   assign IRQ_VECTOR = vector_q;
   assign WAKE_UP    = wake_q;

endmodule // pwu_top

// File: sim/pwu_checker.sv
// port-level assertions for the interrupt unit
`timescale 1ns/1ps
module pwu_checker
   import pwu_pkg::*;
(
   // clock, reset and apb
   input wire logic        CLK_SYS,
   input wire logic        NRST,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [9:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // core side and wake
   input wire logic        IRQ_ACK,
   input wire logic        IRQ_REQ,
   input wire logic [15:0] IRQ_VECTOR,
   input wire logic        POWER_DOWN,
   input wire logic        WAKE_UP
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   logic glob_q;  // global enable as last written
   logic glob_d;  // its next value
   // follow writes to enable_main, the only way the global bit moves
   always_comb begin
      glob_d = glob_q;
      if (PSEL && PENABLE && PWRITE && PADDR == PWU_ADDR_ENABLE_MAIN) begin
         glob_d = PWDATA[PWU_BIT_GLOBAL];
      end
   end
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         glob_q <= 1'b0;
      end else begin
         glob_q <= glob_d;
      end
   end
   zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
      else $error("access phase not ready");
   err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error outside access phase");
   misalign_err_a: assert property (PSEL && PENABLE && PADDR[1:0] != 2'b00 |-> PSLVERR)
      else $error("misaligned access not refused");
   upper_zero_a: assert property (PSEL && PENABLE && !PWRITE
      && PADDR != PWU_ADDR_SERVICE_STATUS |-> PRDATA[31:8] == 24'h0)
      else $error("byte register read with upper bits set");
   vector_set_a: assert property (IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3
      && IRQ_VECTOR <= 16'h0073 && IRQ_VECTOR[7:3] != 5'h04 && IRQ_VECTOR[7:3] != 5'h06)
      else $error("offered vector outside the table");
   ack_drop_a: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ)
      else $error("request still offered after acknowledge");
   global_mask_a: assert property (!glob_q && !$past(glob_q) |-> !IRQ_REQ)
      else $error("request offered with global enable off");
   wake_cause_a: assert property (WAKE_UP |-> $past(POWER_DOWN))
      else $error("wake without power-down");
   cover property (IRQ_REQ && IRQ_ACK);
   cover property (WAKE_UP);
   cover property (PSEL && PENABLE && PSLVERR);
endmodule // pwu_checker

bind pwu_top pwu_checker u_chk (
   .CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
   .PREADY, .PSLVERR, .IRQ_ACK, .IRQ_REQ, .IRQ_VECTOR, .POWER_DOWN, .WAKE_UP
);

// File: sim/pwu_core_model.sv
// cpu core model that takes offered vectors promptly or slowly
`timescale 1ns/1ps
module pwu_core_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // offered request and bench controls
   input wire logic irq_req,
   input wire logic allow,
   input wire logic slow,
   // acknowledge pulse
   output logic     irq_ack
);
   logic [1:0] wait_q;  // cycles waited in slow mode
   logic [1:0] wait_d;
   logic       ack_d;
   // one-cycle pulse, never two in a row, so a dropped request is not taken twice
   always_comb begin
      wait_d = 2'd0;
      ack_d = 1'b0;
      if (!irq_ack && irq_req && allow) begin
         if (!slow || wait_q == 2'd2) begin
            ack_d = 1'b1;
         end else begin
            wait_d = wait_q + 2'd1;
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_q <= 2'd0;
         irq_ack <= 1'b0;
      end else begin
         wait_q <= wait_d;
         irq_ack <= ack_d;
      end
   end
endmodule // pwu_core_model

// File: sim/test_port_wakeup_interrupt_unit.sv
// self-checking bench for the port wakeup interrupt unit
`timescale 1ns/1ps
module test_port_wakeup_interrupt_unit
   import pwu_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwdata = '0;
   logic [4:0]  cls = '0;       // ext0, serial, timer0, ext1, timer1
   logic [7:0]  pins = 8'hFF;   // inactive under reset polarity
   logic        reti = 1'b0;
   logic        pdown = 1'b0;
   logic        allow = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, irq_req, irq_ack, wake;
   logic [15:0] vec;
   logic [32:0] expq [$];       // expected {error, data}, oldest first
   logic [7:0]  pol, rem;
   logic [31:0] v;
   int          n_mismatch = 0;
   int          n_compared = 0;
   logic [9:0]  adr [6] = '{PWU_ADDR_ENABLE_MAIN, PWU_ADDR_PRIORITY_MAIN,
      PWU_ADDR_EXTRA_REQUEST, PWU_ADDR_EXTRA_ENABLE, PWU_ADDR_EXTRA_POLARITY,
      PWU_ADDR_EXTRA_PRIORITY};
   logic [7:0]  msk [6] = '{8'hAF, 8'h2F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   // polling order as source index, and the vector at each place
   int          ord [13] = '{0, 1, 8, 2, 9, 3, 5, 10, 4, 6, 11, 7, 12};
   logic [15:0] vtab [13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h005B,
      16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h006B, 16'h004B, 16'h0073};
   always #2 clk = ~clk;
   pwu_top dut (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .EXT_INPUT_ZERO(cls[0]),
      .TWO_WIRE_PORT_SOURCE(cls[1]), .TIMER_ZERO_SOURCE(cls[2]),
      .EXT_INPUT_ONE(cls[3]), .TIMER_ONE_SOURCE(cls[4]), .EXT_INPUT_EXTRA(pins),
      .IRQ_ACK(irq_ack), .IRQ_RETI(reti), .IRQ_REQ(irq_req), .IRQ_VECTOR(vec),
      .POWER_DOWN(pdown), .WAKE_UP(wake));
   pwu_core_model core (.clk(clk), .nrst(nrst), .irq_req(irq_req), .allow(allow),
      .slow(slow), .irq_ack(irq_ack));
   task chk(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [32:0] nxt();
      if (expq.size() == 0) return 'x;
      return expq.pop_front();
   endfunction
   // each finished read or taken vector meets the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, nxt());
      if (irq_req === 1'b1 && irq_ack === 1'b1) chk({17'h0, vec}, nxt());
   end
   // apb transfer: hold everything until ready is seen high
   task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [9:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // bounded wait for the core to take an offer
   task wait_ack();
      int t;
      t = 0;
      @(posedge clk);
      while (!(irq_req === 1'b1 && irq_ack === 1'b1) && t < 50) begin
         @(posedge clk);
         t++;
      end
      if (t >= 50) chk(33'h0, 33'h1);
   endtask
   task pulse_reti();
      @(posedge clk);
      reti <= 1'b1;
      @(posedge clk);
      reti <= 1'b0;
   endtask
   // take a serviced source away: classic level drops, extra flag is cleared by software
   task drop(input int s);
      if (s < 5) begin
         cls[s] <= 1'b0;
      end else begin
         pins[s-5] <= ~pol[s-5];
         rem[s-5] = 1'b0;
         wr(PWU_ADDR_EXTRA_REQUEST, {24'h0, rem});
      end
   endtask
   task test_done();
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(32'hB880));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) rd(adr[i], 33'h0);
      rd(10'h004, {1'b1, 32'h0});
      rd(PWU_ADDR_ENABLE_MAIN | 10'h001, {1'b1, 32'h0});
      for (int i = 0; i < 6; i++) begin
         v = $urandom;
         wr(adr[i], {24'h0, v[7:0] & msk[i]});
         rd(adr[i], {25'h0, v[7:0] & msk[i]});
         wr(adr[i], 32'h0);
      end
      // only the enabled input latches, at its chosen level, and the flag sticks
      for (int k = 0; k < 8; k++) begin
         pol = 8'($urandom);
         wr(PWU_ADDR_EXTRA_POLARITY, {24'h0, pol});
         pins <= ~pol;
         wr(PWU_ADDR_EXTRA_ENABLE, {24'h0, 8'h01 << k});
         pins <= pol;
         repeat (2) @(posedge clk);
         pins <= ~pol;
         rd(PWU_ADDR_EXTRA_REQUEST, {25'h0, 8'h01 << k});
         rd(PWU_ADDR_EXTRA_POLARITY, {25'h0, pol});
         wr(PWU_ADDR_EXTRA_ENABLE, 32'h0);
         wr(PWU_ADDR_EXTRA_REQUEST, 32'h0);
         rd(PWU_ADDR_EXTRA_REQUEST, 33'h0);
      end
      pdown <= 1'b1;
      pins <= ~pol ^ 8'h10;
      wr(PWU_ADDR_EXTRA_ENABLE, 32'h0000_0010);
      repeat (2) @(posedge clk);
      chk({32'h0, wake}, 33'h1);
      wr(PWU_ADDR_EXTRA_ENABLE, 32'h0);
      repeat (2) @(posedge clk);
      chk({32'h0, wake}, 33'h0);
      pdown <= 1'b0;
      // all thirteen pending at once, taken in polling order, global bit last
      allow <= 1'b1;
      pins <= pol;
      cls <= 5'h1F;
      rem = 8'hFF;
      wr(PWU_ADDR_EXTRA_ENABLE, 32'h0000_00FF);
      wr(PWU_ADDR_ENABLE_MAIN, 32'h0000_002F);
      repeat (3) @(posedge clk);
      chk({32'h0, irq_req}, 33'h0);
      wr(PWU_ADDR_ENABLE_MAIN, 32'h0000_00AF);
      for (int p = 0; p < 13; p++) begin
         expq.push_back({17'h0, vtab[p]});
         slow <= p[0];
         wait_ack();
         drop(ord[p]);
         pulse_reti();
      end
      // high level beats polling order, holds low off, then preempts low
      allow <= 1'b0;
      wr(PWU_ADDR_EXTRA_PRIORITY, 32'h0000_0080);
      cls[0] <= 1'b1;
      pins[7] <= pol[7];
      rem = 8'h80;
      repeat (3) @(posedge clk);
      expq.push_back({17'h0, 16'h0073});
      allow <= 1'b1;
      wait_ack();
      drop(12);
      rd(PWU_ADDR_SERVICE_STATUS, {1'b0, 16'h0073, 8'h00, 8'h0A});
      repeat (4) begin
         @(posedge clk);
         chk({32'h0, irq_req}, 33'h0);
      end
      pulse_reti();
      expq.push_back({17'h0, 16'h0003});
      wait_ack();
      drop(0);
      pins[7] <= pol[7];
      rem = 8'h80;
      expq.push_back({17'h0, 16'h0073});
      wait_ack();
      drop(12);
      pulse_reti();
      pulse_reti();
      repeat (4) @(posedge clk);
      if (expq.size() != 0) n_mismatch++;
      test_done();
   end
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #100000;
      n_mismatch++;
      test_done();
   end
endmodule // test_port_wakeup_interrupt_unit
